// ==== core/line_diag_loopback_pattern.sv ====
// loopback routing, all-ones and pseudo-random pattern generation for a T1/E1 transceiver
// assumes all line, framer and pin inputs are asynchronous to CLK; jitter attenuator and
// analog switches sit outside and follow the control outputs of this block
// Notes on behaviour
// - local loop: receiver off, tx clock and data appear at rx outputs
// - in local loop jitter select still enables and places attenuator, as in every other loop state
// - local loop keeps transmitting tx data, or ones when all-ones set
// - local loop by pin high standalone, or control bit in host mode
// - analog loop disconnects line input, feeds transmit output back to receiver
// - analog loop by local pin at midrange or analog control bit
// - analog loop overrides every other loopback request
// - remote loop ignores tx inputs, bypasses coder, resends rx data at rx clock
// - remote loop leaves recovered clock and data on rx outputs
// - remote loop by control bit in host mode or remote pin high
// - detection searches for 00001 and 001; without it network loop never starts
// - five seconds of activate code starts network loop, same as remote
// - detection enabled by control bit, or remote pin at midrange
// - network loop ends on five seconds of 001, remote/analog, or detection off
// - network loop plus local loop gives dual loop
// - dual loop: tx to rx via attenuator, rx line data back to line
// - all-ones sends continuous ones at tx clock, master clock when absent
// - remote suppresses all-ones; all-ones coexists with local loop
// - all-ones by control bit or all-ones pin high
// - T1 2^20-1 with zero jam after 14; E1 2^15-1 inverted
// - pattern clocked by tx clock, master clock when tx clock absent
// - each rising error insert edge flips one bit, deferred past a jammed bit
// - host mode pattern enabled when select bits are 0 then 1
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module line_diag_loopback_pattern
#(
    parameter int HOLD_CYCLES = line_diag_pkg::CODE_HOLD_CYCLES,
    parameter int LOSS_CYCLES = line_diag_pkg::TXCLK_LOSS_CYCLES,
    parameter int MCLK_DIVIDE = line_diag_pkg::MCLK_DIV
)
(
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // register port
    input wire logic [7:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [15:0] RDATA,
    // mode straps and standalone pins (three-level codes)
    input wire logic HOST_MODE,
    input wire logic E1_MODE,
    input wire logic [1:0] LOCAL_LOOP_SEL,
    input wire logic [1:0] REMOTE_LOOP_SEL,
    input wire logic [1:0] ALL_ONES_SEL,
    input wire logic [1:0] JITTER_PATH_SEL,
    input wire logic LOGIC_ERROR_INSERT,
    // framer side transmit
    input wire logic TX_CLOCK,
    input wire logic TX_POS,
    input wire logic TX_NEG,
    // recovered receive from the receiver
    input wire logic REC_CLOCK,
    input wire logic REC_POS,
    input wire logic REC_NEG,
    // framer side receive outputs
    output logic RX_CLOCK_OUT,
    output logic RX_POS_OUT,
    output logic RX_NEG_OUT,
    // line side transmit outputs
    output logic LINE_TX_CLOCK,
    output logic LINE_TX_POS,
    output logic LINE_TX_NEG,
    // analog and attenuator controls
    output logic RECEIVER_OFF,
    output logic LINE_RX_DISCONNECT,
    output logic CODER_BYPASS,
    output logic JA_ENABLE,
    output logic JA_IN_RX_PATH,
    output logic NETWORK_LOOP_ACTIVE
);
    import line_diag_pkg::*;

    localparam int NSYNC = 17;

    function automatic logic [2:0] ones_of(input logic [4:0] v);
        ones_of = 3'(v[0]) + 3'(v[1]) + 3'(v[2]) + 3'(v[3]) + 3'(v[4]);
    endfunction

    logic [NSYNC-1:0] sync1;
    logic [NSYNC-1:0] sync2;
    logic [NSYNC-1:0] raw;
    logic tx_clk_d, rec_clk_d, ins_d;
    logic [CTRL_W-1:0] ctrl;
    logic host, e1, tx_clk, tx_pos, tx_neg, rec_clk, rec_pos, rec_neg, ins;
    logic [1:0] p_local, p_remote, p_ones, p_ja;
    logic req_local, req_analog, req_remote, det_en, all_ones, pat_en, ja_en, ja_rx;
    logic tx_rise, rec_rise, ins_rise, tx_present, mclk_tick, bit_tick;
    logic [15:0] loss_cnt;
    logic [15:0] div_cnt;
    loop_state_e state;
    loop_state_e next_state;
    logic [5:0] hist;
    logic up_ok, down_ok;
    logic [31:0] up_cnt;
    logic [31:0] down_cnt;
    logic net_active;
    logic [19:0] lfsr;
    logic [3:0] zrun;
    logic err_pending;
    logic fb, jam, pat_bit;
    logic remote_path;

    // two-flop synchroniser on every asynchronous input
    assign raw = {HOST_MODE, E1_MODE, LOCAL_LOOP_SEL, REMOTE_LOOP_SEL, ALL_ONES_SEL,
                  JITTER_PATH_SEL, LOGIC_ERROR_INSERT, TX_CLOCK, TX_POS, TX_NEG,
                  REC_CLOCK, REC_POS, REC_NEG};
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            sync1 <= '0;
            sync2 <= '0;
        end
        else
        begin
            sync1 <= raw;
            sync2 <= sync1;
        end
    end
    assign {host, e1, p_local, p_remote, p_ones, p_ja, ins, tx_clk, tx_pos, tx_neg,
            rec_clk, rec_pos, rec_neg} = sync2;

    // edge detection on synchronised clocks and the error insert pin
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            tx_clk_d <= 1'b0;
            rec_clk_d <= 1'b0;
            ins_d <= 1'b0;
        end
        else
        begin
            tx_clk_d <= tx_clk;
            rec_clk_d <= rec_clk;
            ins_d <= ins;
        end
    end
    assign tx_rise = tx_clk && !tx_clk_d;
    assign rec_rise = rec_clk && !rec_clk_d;
    assign ins_rise = ins && !ins_d;

    // register port: control write, registered read data one cycle later
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            ctrl <= CTRL_W'(CTRL_RESET);
        else if (WR && ADDR == ADDR_CTRL)
            ctrl <= WDATA[CTRL_W-1:0];
    end
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            RDATA <= '0;
        else if (RD && ADDR == ADDR_CTRL)
            RDATA <= 16'(ctrl);
        else if (RD && ADDR == ADDR_STATUS)
            RDATA <= {7'h00, tx_present, net_active, 1'b0, 6'(state)};
        else
            RDATA <= '0;
    end

    // mode requests from pins in standalone mode or control bits in host mode
    assign req_local = host ? ctrl[B_LOCAL] : (p_local == LVL_HIGH);
    assign req_analog = host ? ctrl[B_ANALOG] : (p_local == LVL_MID);
    assign req_remote = host ? ctrl[B_REMOTE] : (p_remote == LVL_HIGH);
    assign det_en = host ? ctrl[B_NETWORK] : (p_remote == LVL_MID);
    assign all_ones = host ? ctrl[B_ALL_ONES] : (p_ones == LVL_HIGH);
    assign pat_en = host ? (!ctrl[B_PAT0] && ctrl[B_PAT1]) : (p_ones == LVL_MID);
    assign ja_en = host ? ctrl[B_JA_EN] : (p_ja != LVL_MID);
    assign ja_rx = host ? ctrl[B_JA_RX] : (p_ja == LVL_HIGH);

    // loop code search on recovered marks, one step per recovered bit
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            hist <= '0;
            up_ok <= 1'b0;
            down_ok <= 1'b0;
        end
        else if (rec_rise)
        begin
            hist <= {hist[4:0], rec_pos | rec_neg};
            up_ok <= (hist[0] == hist[UP_PERIOD]) && (ones_of(hist[4:0]) == 3'h1);
            down_ok <= (hist[0] == hist[DOWN_PERIOD])
                       && (ones_of({2'h0, hist[2:0]}) == 3'h1);
        end
    end

    // persistence timers for activate and deactivate codes
    always_ff @(posedge CLK)
    begin
        if (!RST_N || !det_en || !up_ok)
            up_cnt <= '0;
        else if (up_cnt < 32'(HOLD_CYCLES))
            up_cnt <= up_cnt + 32'h1;
    end
    always_ff @(posedge CLK)
    begin
        if (!RST_N || !det_en || !down_ok)
            down_cnt <= '0;
        else if (down_cnt < 32'(HOLD_CYCLES))
            down_cnt <= down_cnt + 32'h1;
    end

    // network loop flag
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            net_active <= 1'b0;
        else if (!det_en || req_remote || req_analog)
            net_active <= 1'b0;
        else if (down_cnt >= 32'(HOLD_CYCLES))
            net_active <= 1'b0;
        else if (up_cnt >= 32'(HOLD_CYCLES))
            net_active <= 1'b1;
    end

    // loop selection with fixed priority
    always_comb
    begin
        if (req_analog)
            next_state = ST_ANALOG;
        else if (req_local && (req_remote || net_active))
            next_state = ST_DUAL;
        else if (req_remote)
            next_state = ST_REMOTE;
        else if (net_active)
            next_state = ST_NETWORK;
        else if (req_local)
            next_state = ST_LOCAL;
        else
            next_state = ST_NORMAL;
    end
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            state <= ST_NORMAL;
        else
            state <= next_state;
    end

    // tx clock presence watch and master clock divider
    always_ff @(posedge CLK)
    begin
        if (!RST_N || tx_rise)
            loss_cnt <= '0;
        else if (loss_cnt < 16'(LOSS_CYCLES))
            loss_cnt <= loss_cnt + 16'h1;
    end
    assign tx_present = loss_cnt < 16'(LOSS_CYCLES);
    always_ff @(posedge CLK)
    begin
        if (!RST_N || div_cnt >= 16'(MCLK_DIVIDE - 1))
            div_cnt <= '0;
        else
            div_cnt <= div_cnt + 16'h1;
    end
    assign mclk_tick = div_cnt == 16'h0;
    assign bit_tick = tx_present ? tx_rise : mclk_tick;

    // pattern generator with zero jam and error insertion
    assign fb = e1 ? (lfsr[E1_LEN-1] ^ lfsr[E1_TAP-1]) : (lfsr[T1_LEN-1] ^ lfsr[T1_TAP-1]);
    assign jam = !e1 && zrun >= ZERO_RUN_MAX;
    assign pat_bit = (e1 ? !fb : (fb | jam)) ^ (err_pending && !jam);
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            lfsr <= PRBS_SEED;
            zrun <= '0;
        end
        else if (bit_tick)
        begin
            lfsr <= {lfsr[18:0], fb};
            zrun <= (pat_bit || e1) ? 4'h0 : zrun + 4'h1;
        end
    end
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            err_pending <= 1'b0;
        else if (ins_rise) // set wins over the clear
            err_pending <= 1'b1;
        else if (bit_tick && !jam)
            err_pending <= 1'b0;
    end

    // line transmit path
    assign remote_path = state == ST_REMOTE || state == ST_NETWORK || state == ST_DUAL;
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            LINE_TX_POS <= 1'b0;
            LINE_TX_NEG <= 1'b0;
            LINE_TX_CLOCK <= 1'b0;
        end
        else if (remote_path)
        begin
            LINE_TX_CLOCK <= rec_clk;
            if (rec_rise)
            begin
                LINE_TX_POS <= rec_pos;
                LINE_TX_NEG <= rec_neg;
            end
        end
        else
        begin
            LINE_TX_CLOCK <= tx_present ? tx_clk : mclk_tick;
            if (bit_tick)
            begin
                LINE_TX_POS <= all_ones ? 1'b1 : (pat_en ? pat_bit : tx_pos);
                LINE_TX_NEG <= (all_ones || pat_en) ? 1'b0 : tx_neg;
            end
        end
    end

    // receive output path
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            RX_CLOCK_OUT <= 1'b0;
            RX_POS_OUT <= 1'b0;
            RX_NEG_OUT <= 1'b0;
        end
        else if (state == ST_LOCAL || state == ST_DUAL)
        begin
            RX_CLOCK_OUT <= tx_clk;
            RX_POS_OUT <= tx_pos;
            RX_NEG_OUT <= tx_neg;
        end
        else
        begin
            RX_CLOCK_OUT <= rec_clk;
            RX_POS_OUT <= rec_pos;
            RX_NEG_OUT <= rec_neg;
        end
    end

    // analog switch, coder and attenuator controls
    assign RECEIVER_OFF = state == ST_LOCAL || state == ST_DUAL;
    assign LINE_RX_DISCONNECT = state == ST_ANALOG;
    assign CODER_BYPASS = remote_path;
    assign JA_ENABLE = ja_en;
    assign JA_IN_RX_PATH = ja_rx;
    assign NETWORK_LOOP_ACTIVE = net_active;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    a_analog_first: assert property (req_analog |=> state == ST_ANALOG)
        else $error("analog request did not win");
    a_analog_switch: assert property (state == ST_ANALOG |-> LINE_RX_DISCONNECT
        && !RECEIVER_OFF)
        else $error("analog loop switch wrong");
    a_local_route: assert property (state == ST_LOCAL |-> RECEIVER_OFF
        ##1 RX_POS_OUT == $past(tx_pos))
        else $error("local loop rx data not from tx");
    a_ja_place: assert property (state == ST_LOCAL |-> JA_IN_RX_PATH == ja_rx)
        else $error("attenuator placement moved in local loop");
    a_remote_retx: assert property (state == ST_REMOTE && rec_rise |=>
        LINE_TX_POS == $past(rec_pos) && RX_POS_OUT == $past(rec_pos))
        else $error("remote loop did not resend rx data");
    a_ones_local: assert property (state == ST_LOCAL && all_ones && bit_tick
        |=> LINE_TX_POS && !LINE_TX_NEG)
        else $error("all ones lost in local loop");
    a_net_off: assert property (!det_en |=> !net_active)
        else $error("network loop held without detection");
    a_net_start: assert property ($rose(net_active) |-> $past(up_cnt) >= 32'(HOLD_CYCLES))
        else $error("network loop started early");
    a_zero_jam: assert property (!e1 |-> zrun <= ZERO_RUN_MAX)
        else $error("zero run too long");
    a_err_latch: assert property (ins_rise |=> err_pending)
        else $error("error insert edge lost");
    a_dual_sel: assert property (req_local && req_remote && !req_analog
        |=> state == ST_DUAL)
        else $error("dual loop not selected");

    c_local: cover property (state == ST_LOCAL && all_ones);
    c_net: cover property ($rose(net_active));
    c_err: cover property (err_pending && bit_tick && pat_en);
    c_dual: cover property (state == ST_DUAL);
endmodule
`default_nettype wire

// ==== core/line_diag_pkg.sv ====
// constants, codes and state encoding for the line diagnostic loopback and pattern block
// assumes a 125 MHz system clock and synchronous active-low reset
package line_diag_pkg;
    // clock and timing
    localparam int CLK_KHZ = 125000;
    localparam int CODE_HOLD_MS = 5000; // loop code must persist this long
    localparam int CODE_HOLD_CYCLES = CODE_HOLD_MS * CLK_KHZ;
    localparam int TXCLK_LOSS_CYCLES = 64; // no tx clock edge this long = absent
    localparam int MCLK_DIV = 81; // master bit rate divider
    // register port
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // control register fields
    localparam int B_LOCAL = 0;
    localparam int B_ANALOG = 1;
    localparam int B_REMOTE = 2;
    localparam int B_NETWORK = 3;
    localparam int B_ALL_ONES = 4;
    localparam int B_PAT0 = 5;
    localparam int B_PAT1 = 6;
    localparam int B_JA_EN = 7;
    localparam int B_JA_RX = 8;
    localparam int CTRL_W = 9;
    // three-level pin codes from the pad comparators
    localparam logic [1:0] LVL_LOW = 2'h0;
    localparam logic [1:0] LVL_MID = 2'h1;
    localparam logic [1:0] LVL_HIGH = 2'h2;
    // pattern generator
    localparam int T1_LEN = 20;
    localparam int T1_TAP = 17;
    localparam int E1_LEN = 15;
    localparam int E1_TAP = 14;
    localparam logic [3:0] ZERO_RUN_MAX = 4'he;
    localparam logic [19:0] PRBS_SEED = 20'hfffff;
    // loop code periods
    localparam int UP_PERIOD = 5;
    localparam int DOWN_PERIOD = 3;
    typedef enum logic [5:0] {
        ST_NORMAL = 6'h01,
        ST_LOCAL = 6'h02,
        ST_ANALOG = 6'h04,
        ST_REMOTE = 6'h08,
        ST_NETWORK = 6'h10,
        ST_DUAL = 6'h20
    } loop_state_e;
endpackage

// ==== bench/line_far_end_model.sv ====
// far-end model: framer transmit source and recovered receive stream
// assumes the bench seeds $urandom once; both clocks are unrelated to the system clock
`timescale 1ns/1ps
`default_nettype none
module line_far_end_model
(
    // bench controls
    input wire logic tx_run,
    input wire logic [1:0] code_sel,
    // framer transmit
    output logic tx_clock,
    output logic tx_pos,
    output logic tx_neg,
    // recovered receive stream
    output logic rec_clock,
    output logic rec_pos,
    output logic rec_neg
);
    int pos;
    // framer clock stands low while stopped; data moves on the falling edge, never one-hot both
    initial
    begin
        tx_clock = 1'b0;
        tx_pos = 1'b0;
        tx_neg = 1'b0;
        forever
        begin
            #32;
            tx_clock = tx_run & ~tx_clock;
            if (!tx_clock)
            begin
                tx_pos = 1'($urandom);
                tx_neg = ~tx_pos & 1'($urandom);
            end
        end
    end
    // line stream: loop-up code, loop-down code or random marks, one bit per clock
    initial
    begin
        rec_clock = 1'b0;
        rec_pos = 1'b0;
        rec_neg = 1'b0;
        pos = 0;
        #13;
        forever
        begin
            #32;
            rec_clock = ~rec_clock;
            if (!rec_clock)
            begin
                pos = pos + 1;
                rec_pos = (code_sel == 2'h1) ? (pos % 5 == 0) : (code_sel == 2'h2) ? (pos % 3 == 0) : 1'($urandom);
            end
        end
    end
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
// self-checking bench for the loopback and pattern block
// assumes the far-end model drives both link clocks; the loop code hold is shortened
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import line_diag_pkg::*;
    logic clk, rst_n, wr_s, rd_s, host, e1, ins, tx_run, txc, txp, txn, rcc, rcp, rcn;
    logic rxc, rxp, rxn, lc, lp, ln, roff, disc, byp, jae, jar, net;
    logic [7:0] addr;
    logic [15:0] wdata, rdata, r, c;
    logic [1:0] loc, rem, aos, jit, code_sel, ls, rs, js;
    logic q[$];
    logic [15:0] corner [4] = '{16'h0007, 16'h000f, 16'h0005, 16'h0014};
    int err_total, cmp_count, cycles, a, b, o, z;
    line_far_end_model far (.tx_run(tx_run), .code_sel(code_sel), .tx_clock(txc), .tx_pos(txp),
        .tx_neg(txn), .rec_clock(rcc), .rec_pos(rcp), .rec_neg(rcn));
    line_diag_loopback_pattern #(.HOLD_CYCLES(2000)) DUT (.CLK(clk), .RST_N(rst_n), .ADDR(addr),
        .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata), .HOST_MODE(host), .E1_MODE(e1),
        .LOCAL_LOOP_SEL(loc), .REMOTE_LOOP_SEL(rem), .ALL_ONES_SEL(aos), .JITTER_PATH_SEL(jit),
        .LOGIC_ERROR_INSERT(ins), .TX_CLOCK(txc), .TX_POS(txp), .TX_NEG(txn), .REC_CLOCK(rcc),
        .REC_POS(rcp), .REC_NEG(rcn), .RX_CLOCK_OUT(rxc), .RX_POS_OUT(rxp), .RX_NEG_OUT(rxn),
        .LINE_TX_CLOCK(lc), .LINE_TX_POS(lp), .LINE_TX_NEG(ln), .RECEIVER_OFF(roff),
        .LINE_RX_DISCONNECT(disc), .CODER_BYPASS(byp), .JA_ENABLE(jae), .JA_IN_RX_PATH(jar),
        .NETWORK_LOOP_ACTIVE(net));
    // system clock, 8 ns period
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // hang guard
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 90000)
        begin
            err_total++;
            $display("ERROR %0t timeout", $time);
            finish_test();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [15:0] d);
        @(posedge clk);
        addr <= ad;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] ad, output logic [15:0] d);
        @(posedge clk);
        addr <= ad;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 d = rdata;
    endtask
    function automatic loop_state_e exp_state(input logic [4:0] cw);
        if (cw[B_ANALOG]) return ST_ANALOG;
        if (cw[B_REMOTE] && cw[B_LOCAL]) return ST_DUAL;
        if (cw[B_REMOTE]) return ST_REMOTE;
        if (cw[B_LOCAL]) return ST_LOCAL;
        return ST_NORMAL;
    endfunction
    task automatic check_mode(input loop_state_e st, input logic nf);
        logic [15:0] s;
        repeat (8) @(posedge clk);
        rd(ADDR_STATUS, s);
        chk(s, {7'h0, tx_run, nf, 1'b0, st}, "status");
        chk(16'(roff), 16'(st == ST_LOCAL || st == ST_DUAL), "receiver off");
        chk(16'(disc), 16'(st == ST_ANALOG), "line disconnect");
        chk(16'(byp), 16'(st inside {ST_REMOTE, ST_NETWORK, ST_DUAL}), "coder bypass");
    endtask
    // sel 0 rx<-tx, 1 line<-tx, 2 line<-rec, 3 rx<-rec, 4 line all ones
    // rx outputs are a retimed copy and show the current bit at a link clock rise,
    // line outputs are relaunched on each bit edge and still show the previous bit
    task automatic follow(input int sel, input int n);
        int bad;
        logic prev, src, dst, prev_n, src_n, dst_n, now;
        bad = 0;
        prev = 1'bx;
        prev_n = 1'bx;
        now = (sel == 0 || sel == 3);
        for (int i = 0; i < n; i++)
        begin
            if (sel < 2 || sel == 4) @(posedge txc); else @(posedge rcc);
            src = (sel < 2) ? txp : (sel < 4) ? rcp : 1'b1;
            dst = (sel == 0 || sel == 3) ? rxp : lp;
            src_n = (sel < 2) ? txn : (sel < 4) ? rcn : 1'b0;
            dst_n = (sel == 0 || sel == 3) ? rxn : ln;
            if (i > 1 && now && {dst, dst_n} !== {src, src_n}) bad++;
            if (i > 1 && !now && {dst, dst_n} !== {prev, prev_n}) bad++;
            prev = src;
            prev_n = src_n;
        end
        chk(16'(bad), 16'h0, "data path");
    endtask
    task automatic capture(input int n, input logic inject);
        q.delete();
        repeat (3) @(posedge txc);
        for (int i = 0; i < n; i++)
        begin
            @(posedge txc);
            q.push_back(lp);
            if (inject && i == n / 2)
            begin
                @(posedge clk);
                ins <= 1'b1;
                repeat (3) @(posedge clk);
                ins <= 1'b0;
            end
        end
    endtask
    function automatic int rec_bad(input logic s[$], input int gap);
        int m = 0;
        for (int n = 15; n < s.size(); n++)
            if (s[n] !== ~(s[n - gap] ^ s[n - 15])) m++;
        return m;
    endfunction
    // mismatches against the 20-stage recurrence; each jammed bit costs at most three
    function automatic int t1_bad(input logic s[$]);
        int m = 0;
        for (int n = T1_LEN; n < s.size(); n++)
            if (s[n] !== (s[n - T1_LEN] ^ s[n - T1_TAP])) m++;
        return m;
    endfunction
    function automatic int max_zero(input logic s[$]);
        int run = 0;
        int m = 0;
        foreach (s[i])
        begin
            run = (s[i] === 1'b0) ? run + 1 : 0;
            m = (run > m) ? run : m;
        end
        return m;
    endfunction
    task automatic wait_net(input logic v);
        int k;
        k = 0;
        while (net !== v && k < 4000)
        begin
            @(posedge clk);
            k++;
        end
        chk(16'(net), 16'(v), "network flag");
    endtask
    // main sequence
    initial
    begin
        {rst_n, wr_s, rd_s, e1, addr, wdata, code_sel, loc, rem, aos, jit} = '0;
        ins = 1'b0;
        host = 1'b1;
        tx_run = 1'b1;
        {err_total, cmp_count, cycles} = '0;
        void'($urandom(28));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        check_mode(ST_NORMAL, 1'b0);
        rd(8'h08, r);
        chk(r, 16'h0, "unmapped read");
        wr(8'h08, 16'h0001);
        check_mode(ST_NORMAL, 1'b0);
        $display("test reset and map done");
        for (int i = 0; i < 24; i++)
        begin
            c = (i < 4) ? corner[i] : 16'($urandom) & 16'h019f;
            wr(ADDR_CTRL, c);
            check_mode(exp_state(c[4:0]), 1'b0);
            rd(ADDR_CTRL, r);
            chk(r, c, "control readback");
            chk(16'({jae, jar}), 16'({c[B_JA_EN], c[B_JA_RX]}), "attenuator");
        end
        $display("test host selection done");
        wr(ADDR_CTRL, 16'h0011);
        follow(0, 40);
        follow(4, 40);
        wr(ADDR_CTRL, 16'h0001);
        follow(1, 40);
        wr(ADDR_CTRL, 16'h0014);
        follow(2, 40);
        follow(3, 40);
        wr(ADDR_CTRL, 16'h0010);
        follow(4, 40);
        $display("test data paths done");
        host <= 1'b0;
        for (int i = 0; i < 24; i++)
        begin
            ls = 2'($urandom % 3);
            rs = 2'($urandom % 3);
            js = 2'($urandom % 3);
            @(posedge clk);
            {loc, rem, jit} <= {ls, rs, js};
            check_mode(exp_state({2'b00, rs == LVL_HIGH, ls == LVL_MID, ls == LVL_HIGH}), 1'b0);
            chk(16'({jae, jar}), 16'({js != LVL_MID, js == LVL_HIGH}), "attenuator pins");
        end
        {loc, rem, aos} <= {LVL_LOW, LVL_LOW, LVL_HIGH};
        follow(4, 40);
        aos <= LVL_LOW;
        host <= 1'b1;
        $display("test standalone pins done");
        e1 <= 1'b1;
        wr(ADDR_CTRL, 16'h0040);
        capture(300, 1'b0);
        a = rec_bad(q, 14);
        b = rec_bad(q, 1);
        chk(16'((a < b) ? a : b), 16'h0, "e1 sequence");
        chk(16'(max_zero(q) > 0), 16'h1, "e1 not constant");
        capture(300, 1'b1);
        a = rec_bad(q, 14);
        b = rec_bad(q, 1);
        chk(16'((a < b) ? a : b), 16'h3, "single error");
        e1 <= 1'b0;
        capture(2000, 1'b0);
        chk(16'(max_zero(q) > 0 && max_zero(q) <= 14), 16'h1, "t1 zero run");
        chk(16'(t1_bad(q) < 8), 16'h1, "t1 sequence");
        tx_run <= 1'b0;
        repeat (200) @(posedge clk);
        {o, z} = '0;
        repeat (6000)
        begin
            @(posedge clk);
            if (lp === 1'b1) o++; else if (lp === 1'b0) z++;
        end
        chk(16'(o > 0 && z > 0), 16'h1, "master clock pattern");
        check_mode(ST_NORMAL, 1'b0);
        tx_run <= 1'b1;
        $display("test pattern done");
        wr(ADDR_CTRL, 16'h0000);
        code_sel <= 2'h1;
        repeat (3000) @(posedge clk);
        chk(16'(net), 16'h0, "no detection");
        wr(ADDR_CTRL, 16'h0008);
        repeat (1800) @(posedge clk);
        chk(16'(net), 16'h0, "early network");
        wait_net(1'b1);
        wr(ADDR_CTRL, 16'h0009);
        check_mode(ST_DUAL, 1'b1);
        wr(ADDR_CTRL, 16'h0008);
        check_mode(ST_NETWORK, 1'b1);
        follow(2, 40);
        wr(ADDR_CTRL, 16'h000c);
        check_mode(ST_REMOTE, 1'b0);
        wr(ADDR_CTRL, 16'h0008);
        wait_net(1'b1);
        code_sel <= 2'h2;
        wait_net(1'b0);
        check_mode(ST_NORMAL, 1'b0);
        code_sel <= 2'h1;
        wait_net(1'b1);
        wr(ADDR_CTRL, 16'h0000);
        check_mode(ST_NORMAL, 1'b0);
        $display("test network loop done");
        finish_test();
    end
endmodule
`default_nettype wire
